// *** bk2_params.svh ***
/*
 Constants for the buck-2 control register bank: register indexes, field
 positions, reset values and soft-start timing. Assumes a 25 MHz system clock.
*/
// Behaviour
// RULE1 - Disabled converter: discharge if float bit clear
// RULE2 - Start-up steps current limit exactly eight times
// RULE3 - Step field selects 32/64/128/256 us steps
// RULE4 - Capacitor field: 00 small, 10 large range
// RULE5 - Capacitor field loads only from configuration load
// RULE6 - Undervoltage: ignore, shut converter, or system reset
// RULE7 - Undervoltage always raises the interrupt; the code always sets status bit 0 but drives IRQ_O only when mask bit 0 is set
// RULE8 - Reserved action code behaves as ignore
`ifndef BK2_PARAMS_SVH
`define BK2_PARAMS_SVH

`define BK2_AXI_AW 18
`define BK2_IDX_CTL1 16'h405B
`define BK2_IDX_CTL2 16'h405C
`define BK2_IDX_RUN 16'h4060
`define BK2_IDX_STAT 16'h4061
`define BK2_IDX_MASK 16'h4062

`define BK2_FLT_BIT 7
`define BK2_SS_LSB 4
`define BK2_CAP_LSB 0
`define BK2_ACT_LSB 14
`define BK2_RUN_BIT 0
`define BK2_IRQ_UV 0
`define BK2_IRQ_SS 1

`define BK2_RST_FLT 1'h0
`define BK2_RST_SS 2'h0
`define BK2_RST_CAP 2'h0
`define BK2_RST_ACT 2'h0

`define BK2_CLK_MHZ 25
`define BK2_SS_T0_US 32
`define BK2_SS_T1_US 64
`define BK2_SS_T2_US 128
`define BK2_SS_T3_US 256
`define BK2_SS_STEPS 4'h8

`define BK2_RESP_OKAY 2'h0
`define BK2_RESP_SLVERR 2'h2

`endif

// *** bk2_pkg.sv ***
/*
 Types for the buck-2 control bank: undervoltage action codes and soft-start
 states. Assumes nothing beyond the parameter header.
*/
`default_nettype none
package bk2_pkg;

    typedef enum logic [1:0] {
        ACT_IGNORE = 2'h0,
        ACT_SHUT = 2'h1,
        ACT_SYSRST = 2'h2,
        ACT_RSVD = 2'h3
    } bk2_act_e;

    typedef enum logic [2:0] {
        SS_IDLE = 3'h1,
        SS_RAMP = 3'h2,
        SS_DONE = 3'h4
    } bk2_ss_e;

endpackage
`default_nettype wire

// *** bk2_ss_if.sv ***
/*
 Carrier between the register bank and the soft-start step timer.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface bk2_ss_if;
    logic run;
    logic [15:0] step_cyc;
    logic [3:0] step;
    logic done;
    modport ctrl (output run, output step_cyc, input step, input done);
    modport timer (input run, input step_cyc, output step, output done);
endinterface
`default_nettype wire

// *** bk2_softstart.sv ***
/*
 Soft-start step timer: while run is high, counts a fixed number of current
 limit steps, each step_cyc clocks long. Assumes run and step_cyc are
 synchronous to CLK_I.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bk2_params.svh"
module bk2_softstart (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    bk2_ss_if.timer ss
);
    bk2_pkg::bk2_ss_e state_q;
    logic [15:0] cnt_q;
    logic [3:0] step_q;
    logic step_end;

    assign step_end = (cnt_q >= ss.step_cyc - 16'h0001);
    assign ss.step = step_q;
    assign ss.done = (state_q == bk2_pkg::SS_DONE);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= bk2_pkg::SS_IDLE;
            cnt_q <= 16'h0000;
            step_q <= 4'h0;
        end else if (!ss.run) begin
            state_q <= bk2_pkg::SS_IDLE;
            cnt_q <= 16'h0000;
            step_q <= 4'h0;
        end else begin
            case (state_q)
                bk2_pkg::SS_IDLE: begin
                    state_q <= bk2_pkg::SS_RAMP;
                    cnt_q <= 16'h0000;
                    step_q <= 4'h1;
                end
                bk2_pkg::SS_RAMP: begin
                    // Live field: a change mid-ramp applies from the next clock
                    if (step_end) begin
                        cnt_q <= 16'h0000;
                        if (step_q == `BK2_SS_STEPS) begin
                            state_q <= bk2_pkg::SS_DONE; // RULE2
                        end else begin
                            step_q <= step_q + 4'h1; // RULE2
                        end
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                bk2_pkg::SS_DONE: begin
                    state_q <= bk2_pkg::SS_DONE;
                end
                default: begin
                    state_q <= bk2_pkg::SS_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** bk2_ctrl.sv ***
/*
 Buck-2 control register bank behind an AXI4-Lite slave: float/discharge
 choice, soft-start timing, capacitor range, undervoltage policy and
 interrupt. Assumes UV_I, CFG_LOAD_I and CFG_CAP_I are asynchronous pins and
 that the bus runs on CLK_I.
*/
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "bk2_params.svh"
module bk2_ctrl #(
    parameter logic [15:0] SS_CYC_0 = 16'(`BK2_SS_T0_US * `BK2_CLK_MHZ),
    parameter logic [15:0] SS_CYC_1 = 16'(`BK2_SS_T1_US * `BK2_CLK_MHZ),
    parameter logic [15:0] SS_CYC_2 = 16'(`BK2_SS_T2_US * `BK2_CLK_MHZ),
    parameter logic [15:0] SS_CYC_3 = 16'(`BK2_SS_T3_US * `BK2_CLK_MHZ)
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [`BK2_AXI_AW-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [`BK2_AXI_AW-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic UV_I,
    input wire logic CFG_LOAD_I,
    input wire logic [1:0] CFG_CAP_I,
    output logic CONV_EN_O,
    output logic DISCHARGE_O,
    output logic [3:0] ILIM_STEP_O,
    output logic SS_DONE_O,
    output logic SYS_RESET_REQ_O,
    output logic IRQ_O
);
    localparam int AW = `BK2_AXI_AW;

    // Register select, one bit per register: ctl1, ctl2, run, stat, mask
    function automatic logic [4:0] reg_sel(input logic [AW-1:0] a);
        logic [15:0] idx;
        idx = a[AW-1:2];
        reg_sel = {idx == `BK2_IDX_MASK, idx == `BK2_IDX_STAT, idx == `BK2_IDX_RUN,
                   idx == `BK2_IDX_CTL2, idx == `BK2_IDX_CTL1};
    endfunction

    bk2_ss_if ss ();

    // Pin synchronisers; first stage feeds only the second
    logic uv_s1_q, uv_s2_q, uv_s3_q;
    logic ld_s1_q, ld_s2_q, ld_s3_q;
    logic [1:0] cap_s1_q, cap_s2_q;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            uv_s1_q <= 1'h0;
            uv_s2_q <= 1'h0;
            uv_s3_q <= 1'h0;
            ld_s1_q <= 1'h0;
            ld_s2_q <= 1'h0;
            ld_s3_q <= 1'h0;
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
        end else begin
            uv_s1_q <= UV_I;
            uv_s2_q <= uv_s1_q;
            uv_s3_q <= uv_s2_q;
            ld_s1_q <= CFG_LOAD_I;
            ld_s2_q <= ld_s1_q;
            ld_s3_q <= ld_s2_q;
            cap_s1_q <= CFG_CAP_I;
            cap_s2_q <= cap_s1_q;
        end
    end

    logic uv_rise, ld_rise;
    assign uv_rise = uv_s2_q & ~uv_s3_q;
    assign ld_rise = ld_s2_q & ~ld_s3_q;

    // Write channel: address and data held independently, then one write
    logic aw_held_q, w_held_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_hs, w_hs, do_write;
    logic [4:0] wsel;

    assign aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign do_write = aw_held_q & w_held_q & ~S_AXI_BVALID_O;
    assign wsel = reg_sel(awaddr_q);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            aw_held_q <= 1'h0;
            w_held_q <= 1'h0;
            awaddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            S_AXI_AWREADY_O <= 1'h1;
            S_AXI_WREADY_O <= 1'h1;
            S_AXI_BVALID_O <= 1'h0;
            S_AXI_BRESP_O <= `BK2_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_held_q <= 1'h1;
                awaddr_q <= S_AXI_AWADDR_I;
                S_AXI_AWREADY_O <= 1'h0;
            end
            if (w_hs) begin
                w_held_q <= 1'h1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
                S_AXI_WREADY_O <= 1'h0;
            end
            if (do_write) begin
                aw_held_q <= 1'h0;
                w_held_q <= 1'h0;
                S_AXI_BVALID_O <= 1'h1;
                S_AXI_BRESP_O <= (wsel != 5'h00) ? `BK2_RESP_OKAY : `BK2_RESP_SLVERR;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'h0;
                S_AXI_AWREADY_O <= 1'h1;
                S_AXI_WREADY_O <= 1'h1;
            end
        end
    end

    // Register fields
    logic flt_q, run_q;
    logic [1:0] ss_q, cap_q, act_q, stat_q, mask_q;
    logic lane0;

    assign lane0 = do_write & wstrb_q[0];

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            flt_q <= `BK2_RST_FLT;
            ss_q <= `BK2_RST_SS;
        end else if (lane0 && wsel[0]) begin
            flt_q <= wdata_q[`BK2_FLT_BIT];
            ss_q <= wdata_q[`BK2_SS_LSB +: 2];
        end
    end

    // Bus writes never reach the capacitor field
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cap_q <= `BK2_RST_CAP;
        end else if (ld_rise) begin
            cap_q <= cap_s2_q; // RULE5 RULE4
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            act_q <= `BK2_RST_ACT;
        end else if (do_write && wstrb_q[1] && wsel[1]) begin
            act_q <= wdata_q[`BK2_ACT_LSB +: 2];
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            mask_q <= 2'h0;
        end else if (lane0 && wsel[4]) begin
            mask_q <= wdata_q[1:0];
        end
    end

    // Undervoltage policy; shutdown wins over a same-cycle enable write
    bk2_pkg::bk2_act_e act;
    assign act = bk2_pkg::bk2_act_e'(act_q);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            run_q <= 1'h0;
        end else if (uv_rise && act == bk2_pkg::ACT_SHUT) begin
            run_q <= 1'h0; // RULE6
        end else if (lane0 && wsel[2]) begin
            run_q <= wdata_q[`BK2_RUN_BIT];
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SYS_RESET_REQ_O <= 1'h0;
        end else begin
            // Reserved code falls through to no action
            SYS_RESET_REQ_O <= uv_rise && act == bk2_pkg::ACT_SYSRST; // RULE6 RULE8
        end
    end

    // Soft-start timer
    assign ss.run = run_q;
    always_comb begin
        case (ss_q)
            2'h0: ss.step_cyc = SS_CYC_0; // RULE3
            2'h1: ss.step_cyc = SS_CYC_1;
            2'h2: ss.step_cyc = SS_CYC_2;
            default: ss.step_cyc = SS_CYC_3;
        endcase
    end

    bk2_softstart u_ss (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .ss(ss.timer)
    );

    logic ss_done_q;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ss_done_q <= 1'h0;
        end else begin
            ss_done_q <= ss.done;
        end
    end

    // Read channel
    logic ar_hs;
    logic [4:0] rsel;
    logic [15:0] rd_val;
    assign ar_hs = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign rsel = reg_sel(S_AXI_ARADDR_I);

    always_comb begin
        rd_val = 16'h0000;
        if (rsel[0]) begin
            rd_val[`BK2_FLT_BIT] = flt_q;
            rd_val[`BK2_SS_LSB +: 2] = ss_q;
            rd_val[`BK2_CAP_LSB +: 2] = cap_q;
        end
        if (rsel[1]) begin
            rd_val[`BK2_ACT_LSB +: 2] = act_q;
        end
        if (rsel[2]) begin
            rd_val[`BK2_RUN_BIT] = run_q;
        end
        if (rsel[3]) begin
            rd_val[1:0] = stat_q;
        end
        if (rsel[4]) begin
            rd_val[1:0] = mask_q;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            S_AXI_ARREADY_O <= 1'h1;
            S_AXI_RVALID_O <= 1'h0;
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= `BK2_RESP_OKAY;
        end else if (ar_hs) begin
            S_AXI_ARREADY_O <= 1'h0;
            S_AXI_RVALID_O <= 1'h1;
            S_AXI_RDATA_O <= {16'h0000, rd_val};
            S_AXI_RRESP_O <= (rsel != 5'h00) ? `BK2_RESP_OKAY : `BK2_RESP_SLVERR;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'h0;
            S_AXI_ARREADY_O <= 1'h1;
        end
    end

    // Sticky status; a new event beats the read-clear
    logic [1:0] stat_set;
    assign stat_set = {ss.done & ~ss_done_q, uv_rise}; // RULE7

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= (stat_q & ~{2{ar_hs & rsel[3]}}) | stat_set;
        end
    end

    // Outputs, all registered
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            CONV_EN_O <= 1'h0;
            DISCHARGE_O <= 1'h0;
            ILIM_STEP_O <= 4'h0;
            SS_DONE_O <= 1'h0;
            IRQ_O <= 1'h0;
        end else begin
            CONV_EN_O <= run_q;
            DISCHARGE_O <= ~run_q & ~flt_q; // RULE1
            ILIM_STEP_O <= ss.step; // RULE2
            SS_DONE_O <= ss.done;
            IRQ_O <= |(stat_q & mask_q);
        end
    end
endmodule
`default_nettype wire

// *** bk2_ctrl_sva.sv ***
/*
 Checker for the buck-2 control bank: output relations at the top ports.
 Assumes one clock and the asynchronous active-high reset of bk2_ctrl.
*/
`timescale 1ns/1ns
`default_nettype none
module bk2_ctrl_sva (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic S_AXI_BVALID_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_RVALID_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic UV_I,
    input wire logic CONV_EN_O,
    input wire logic DISCHARGE_O,
    input wire logic [3:0] ILIM_STEP_O,
    input wire logic SS_DONE_O,
    input wire logic SYS_RESET_REQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_resp_wait;
        S_AXI_BVALID_O && !S_AXI_BREADY_I;
    endsequence
    sequence s_uv_held;
        UV_I ##1 UV_I;
    endsequence
    // Enabled converter never discharges its own output
    a_no_discharge: assert property (CONV_EN_O && $past(CONV_EN_O) |-> !DISCHARGE_O)
        else $error("discharge while enabled");
    a_step_max: assert property (ILIM_STEP_O <= 4'h8)
        else $error("step above eight");
    a_done_eight: assert property (SS_DONE_O |-> ILIM_STEP_O == 4'h8)
        else $error("done before step eight");
    a_step_order: assert property (($past(ILIM_STEP_O) != 4'h0 && ILIM_STEP_O != 4'h0 && $changed(ILIM_STEP_O))
        |-> ILIM_STEP_O == $past(ILIM_STEP_O) + 4'h1)
        else $error("step skipped");
    a_reset_pulse: assert property (SYS_RESET_REQ_O |=> !SYS_RESET_REQ_O)
        else $error("reset request too long");
    // Pin path is synchronised, so the cause lies a few edges back
    a_reset_cause: assert property ($rose(SYS_RESET_REQ_O) |-> $past(UV_I, 2) || $past(UV_I, 3) || $past(UV_I, 4))
        else $error("reset request without undervoltage");
    a_bresp_hold: assert property (s_resp_wait |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped");
    a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped");
    c_uv_held: cover property (s_uv_held);
endmodule
bind bk2_ctrl bk2_ctrl_sva u_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RREADY_I(S_AXI_RREADY_I), .UV_I(UV_I), .CONV_EN_O(CONV_EN_O),
    .DISCHARGE_O(DISCHARGE_O), .ILIM_STEP_O(ILIM_STEP_O), .SS_DONE_O(SS_DONE_O),
    .SYS_RESET_REQ_O(SYS_RESET_REQ_O));
`default_nettype wire

// *** tb_buck2_ctrl_fields.sv ***
/*
 Self-checking bench for bk2_ctrl with an integer model of the bank.
 Assumes short soft-start steps of 4..7 clocks set by parameters.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bk2_params.svh"
module tb_buck2_ctrl_fields;
    logic clk = 0, rst = 1, aw = 0, wv = 0, bre = 0, ar = 0, rre = 0, uv = 0, ld = 0;
    logic [17:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rnd;
    logic [1:0] capi = 0, bresp, rresp;
    logic awr, wrd, bv, arr, rv, en, dis, done, sreq, irq;
    logic [3:0] stp;
    int num_errors = 0, tests_run = 0, cyc = 0, flt = 0, ss = 0, cap = 0, run = 0, n[9], p;
    bk2_ctrl #(.SS_CYC_0(16'h4), .SS_CYC_1(16'h5), .SS_CYC_2(16'h6), .SS_CYC_3(16'h7)) dut_u (
        .CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(aw), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'h3), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara),
        .S_AXI_ARVALID_I(ar), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .UV_I(uv), .CFG_LOAD_I(ld), .CFG_CAP_I(capi),
        .CONV_EN_O(en), .DISCHARGE_O(dis), .ILIM_STEP_O(stp), .SS_DONE_O(done), .SYS_RESET_REQ_O(sreq),
        .IRQ_O(irq));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Each channel released once taken; one edge between calls so no signal is set twice in a step
    // Random late ready makes the slave hold its answer
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        aw <= 1;
        wv <= 1;
        awa <= {idx, 2'h0};
        wd <= d;
        bre <= 1'($urandom);
        do begin
            @(posedge clk);
            if (awr) aw <= 0;
            if (wrd) wv <= 0;
            if (bv && !bre) bre <= 1;
        end while (!(bv && bre));
        bre <= 0;
        chk(bresp, er);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ar <= 1;
        ara <= {idx, 2'h0};
        rre <= 1'($urandom);
        do begin
            @(posedge clk);
            if (arr) ar <= 0;
            if (rv && !rre) rre <= 1;
        end while (!(rv && rre));
        rre <= 0;
        chk(rd, e);
        chk(rresp, er);
    endtask
    function automatic logic [31:0] ctl1();
        return 32'(flt * 128 + ss * 16 + cap);
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(78971));
        tick(2);
        rst <= 0;
        tick(2);
        for (int i = 0; i < 5; i++) rdc(i < 2 ? 16'h405B + 16'(i) : 16'h405E + 16'(i), 32'h0, 2'h0);
        rdc(16'h4063, 32'h0, `BK2_RESP_SLVERR);
        wr(16'h4070, 32'hFFFF, `BK2_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            rnd = $urandom;
            flt = rnd[7];
            ss = rnd[5:4];
            wr(`BK2_IDX_CTL1, rnd, 2'h0);
            rdc(`BK2_IDX_CTL1, ctl1(), 2'h0);
            tick(3);
            chk(dis, 32'(!flt));
            capi <= 2'(i);
            ld <= 1;
            tick(4);
            ld <= 0;
            cap = i;
            tick(4);
            rdc(`BK2_IDX_CTL1, ctl1(), 2'h0);
        end
        wr(`BK2_IDX_MASK, 32'h2, 2'h0);
        for (int c = 0; c < 4; c++) begin
            ss = c;
            wr(`BK2_IDX_CTL1, 32'(c * 16), 2'h0);
            wr(`BK2_IDX_RUN, 32'h1, 2'h0);
            foreach (n[i]) n[i] = 0;
            for (int k = 0; k < 200 && !done; k++) begin
                @(posedge clk);
                if (!done) n[stp]++;
            end
            for (int k = 1; k < 9; k++) chk(n[k], 32'(c + 4));
            chk(done, 32'h1);
            chk(dis, 32'h0);
            tick(2);
            chk(irq, 32'h1);
            rdc(`BK2_IDX_STAT, 32'h2, 2'h0);
            tick(2);
            chk(irq, 32'h0);
            wr(`BK2_IDX_RUN, 32'h0, 2'h0);
            tick(3);
            chk(stp, 32'h0);
            chk(done, 32'h0);
        end
        // Reserved code masked off to prove the mask gates the line
        for (int a = 0; a < 4; a++) begin
            wr(`BK2_IDX_CTL2, 32'(a << 14), 2'h0);
            rdc(`BK2_IDX_CTL2, 32'(a << 14), 2'h0);
            wr(`BK2_IDX_MASK, a == 3 ? 32'h0 : 32'h1, 2'h0);
            wr(`BK2_IDX_RUN, 32'h1, 2'h0);
            tick(80);
            rdc(`BK2_IDX_STAT, 32'h2, 2'h0);
            p = 0;
            uv <= 1;
            for (int k = 0; k < 10; k++) begin
                @(posedge clk);
                p += sreq;
            end
            uv <= 0;
            run = (a == 1) ? 0 : 1;
            chk(p, 32'(a == 2));
            chk(en, 32'(run));
            chk(irq, 32'(a != 3));
            rdc(`BK2_IDX_STAT, 32'h1, 2'h0);
            rdc(`BK2_IDX_RUN, 32'(run), 2'h0);
            wr(`BK2_IDX_RUN, 32'h0, 2'h0);
            tick(90);
            rdc(`BK2_IDX_STAT, 32'h0, 2'h0);
        end
        close_out();
    end
endmodule
`default_nettype wire
